// [rtl/ssm_top.sv]
// stop method, warning mask, current offset and commutation parameter bank of a servo drive
// assumes an apb master on pclk and drive inputs synchronous to pclk
//
// Overview of operation
// - travel limit or emergency stop input starts the stop; method accepts 0 or 1
// - method zero stops according to the dynamic brake control mode
// - method zero holds torque command at zero, with dynamic brake while stopping only in brake modes 0 and 1
// - method one decelerates to standstill using the emergency stop torque limit
// - torque control mode never uses the torque-limited deceleration stop
// - a set warning mask bit keeps that warning from being raised
// - mask bits 0-3: phase loss, battery low, soft limit, brake overcurrent
// - mask bits 4-7: overload, motor mismatch, undervoltage, emergency input
// - mask bit 14 suppresses the index loss alarm
// - each phase subtracts its signed offset, 0.1% steps, -1000 to 1000
// - small or medium drives ignore the w phase offset
// - offset tuning results become readable in the offset registers
// - pole pitch in 0.01 mm equals one electrical revolution
// - scale resolution is nanometres per count, 1000 for one micrometre
// - method 0 none or hall, 1 at first servo on, 2 reserved
// - commutation current in 0.1% steps, initial value 500
// - commutation time in milliseconds sets the commutation duration
// - brake mode 0-3: hold/release after braked stop, release/hold after coast
`timescale 1ns/100ps
`default_nettype none
`include "ssm_regs.svh"

module ssm_top #(
	parameter int TICKS_PER_MS = `SSM_CLK_HZ / `SSM_MS_PER_S
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic positive_travel_limit_input,
	input wire logic negative_travel_limit_input,
	input wire logic emergency_stop_input,
	input wire logic torque_mode,
	input wire logic motor_standstill,
	input wire logic servo_on,
	input wire logic large_drive,
	input wire logic [7:0] warning_raw,
	input wire logic index_loss_alarm_raw,
	input wire logic tune_valid,
	input wire logic [15:0] tune_u,
	input wire logic [15:0] tune_v,
	input wire logic [15:0] tune_w,
	input wire logic [15:0] meas_u,
	input wire logic [15:0] meas_v,
	input wire logic [15:0] meas_w,
	output logic [15:0] ctrl_u,
	output logic [15:0] ctrl_v,
	output logic [15:0] ctrl_w,
	output logic stop_active,
	output logic dynamic_brake,
	output logic torque_zero,
	output logic decel_stop,
	output logic [7:0] warning_out,
	output logic index_loss_alarm,
	output logic [15:0] pole_pitch,
	output logic [15:0] scale_size,
	output logic angle_on_first_servo,
	output logic angle_active,
	output logic [15:0] angle_current
);

	localparam int TW = $clog2(TICKS_PER_MS + 1);

	typedef struct packed {
		logic [15:0] db_mode;
		logic [15:0] stop_method;
		logic [15:0] wmask;
		logic [15:0] ofs_u;
		logic [15:0] ofs_v;
		logic [15:0] ofs_w;
		logic [15:0] pole_w;
		logic [15:0] scale_w;
		logic [15:0] meth_w;
		logic [15:0] ang_cur;
		logic [15:0] ang_time;
		logic [15:0] pole_a;
		logic [15:0] scale_a;
		logic [15:0] meth_a;
		logic boot;
		ssm_pkg::ssm_stop_t stop;
		logic [TW-1:0] tick;
		logic [15:0] ms;
		logic ang_act;
		logic ang_used;
		logic ang_first;
		logic servo_d;
		logic [`SSM_IRQ_W-1:0] ists;
		logic [`SSM_IRQ_W-1:0] ien;
		logic [7:0] warn;
		logic alarm;
		logic dbrake;
		logic tzero;
		logic decel;
		logic stopping;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
	} ssm_state_t;

	ssm_state_t s_q;
	ssm_state_t s_d;
	ssm_cur_if cur ();

	// ========================================================================
	// helpers
	// ========================================================================
	function automatic logic ofs_ok(input logic [15:0] v);
		ofs_ok = ($signed(v) <= `SSM_OFS_LIMIT) && ($signed(v) >= -`SSM_OFS_LIMIT);
	endfunction

	function automatic logic [31:0] widen(input logic [15:0] v);
		widen = {16'h0000, v};
	endfunction

	// hold after the stop for modes that keep the brake closed
	function automatic logic db_hold(input logic [15:0] m);
		db_hold = (m[1:0] == ssm_pkg::SSM_DB_HOLD_BRAKED) || (m[1:0] == ssm_pkg::SSM_DB_HOLD_COAST);
	endfunction

	// ========================================================================
	// next state
	// ========================================================================
	logic [13:0] idx;
	logic setup;
	logic wr;
	logic hit;
	logic [31:0] rd;
	logic trig;
	logic [7:0] warn_n;
	logic alarm_n;
	logic [`SSM_IRQ_W-1:0] ev;
	logic comm_done;

	always_comb
	begin
		s_d = s_q;
		idx = paddr[15:2];
		setup = psel && !penable;
		wr = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
		hit = 1'b1;
		rd = 32'h0000_0000;
		comm_done = 1'b0;

		// geometry and method follow the written values until the first servo on
		// after reset, then stay frozen so a running axis never changes geometry
		s_d.boot = s_q.boot || (servo_on && !s_q.servo_d);
		if (!s_q.boot)
		begin
			s_d.pole_a = s_q.pole_w;
			s_d.scale_a = s_q.scale_w;
			s_d.meth_a = s_q.meth_w;
		end
		s_d.ang_first = (s_d.meth_a == 16'h0001);

		// read decode
		case (idx)
			`SSM_IDX_DB_MODE: rd = widen(s_q.db_mode);
			`SSM_IDX_STOP_METHOD: rd = widen(s_q.stop_method);
			`SSM_IDX_WARN_MASK: rd = widen(s_q.wmask);
			`SSM_IDX_OFS_U: rd = widen(s_q.ofs_u);
			`SSM_IDX_OFS_V: rd = widen(s_q.ofs_v);
			`SSM_IDX_OFS_W: rd = widen(s_q.ofs_w);
			`SSM_IDX_POLE_PITCH: rd = widen(s_q.pole_w);
			`SSM_IDX_SCALE_SIZE: rd = widen(s_q.scale_w);
			`SSM_IDX_ANGLE_METHOD: rd = widen(s_q.meth_w);
			`SSM_IDX_ANGLE_CURRENT: rd = widen(s_q.ang_cur);
			`SSM_IDX_ANGLE_DURATION: rd = widen(s_q.ang_time);
			`SSM_IDX_IRQ_STATUS: rd = {21'h000000, s_q.ists};
			`SSM_IDX_IRQ_CLEAR: rd = 32'h0000_0000;
			`SSM_IDX_IRQ_ENABLE: rd = {21'h000000, s_q.ien};
			default: hit = 1'b0;
		endcase

		// apb: one wait-free access phase after every setup
		s_d.pready = setup;
		if (setup)
		begin
			s_d.prdata = pwrite ? 32'h0000_0000 : rd;
			s_d.pslverr = !hit;
		end

		// register writes; out-of-range values are dropped
		if (wr)
		begin
			case (idx)
				`SSM_IDX_DB_MODE:
					if (pwdata[15:0] <= `SSM_MAX_DB_MODE)
						s_d.db_mode = pwdata[15:0];
				`SSM_IDX_STOP_METHOD:
					if (pwdata[15:0] <= `SSM_MAX_STOP_METHOD)
						s_d.stop_method = pwdata[15:0];
				`SSM_IDX_WARN_MASK: s_d.wmask = pwdata[15:0];
				`SSM_IDX_OFS_U:
					if (ofs_ok(pwdata[15:0]))
						s_d.ofs_u = pwdata[15:0];
				`SSM_IDX_OFS_V:
					if (ofs_ok(pwdata[15:0]))
						s_d.ofs_v = pwdata[15:0];
				`SSM_IDX_OFS_W:
					if (ofs_ok(pwdata[15:0]))
						s_d.ofs_w = pwdata[15:0];
				`SSM_IDX_POLE_PITCH:
					if (pwdata[15:0] != 16'h0000)
						s_d.pole_w = pwdata[15:0];
				`SSM_IDX_SCALE_SIZE:
					if (pwdata[15:0] != 16'h0000)
						s_d.scale_w = pwdata[15:0];
				`SSM_IDX_ANGLE_METHOD:
					if (pwdata[15:0] <= `SSM_MAX_ANGLE_METHOD)
						s_d.meth_w = pwdata[15:0];
				`SSM_IDX_ANGLE_CURRENT:
					if (pwdata[15:0] <= `SSM_MAX_ANGLE_CURRENT)
						s_d.ang_cur = pwdata[15:0];
				`SSM_IDX_ANGLE_DURATION:
					if (pwdata[15:0] >= `SSM_MIN_ANGLE_DURATION
						&& pwdata[15:0] <= `SSM_MAX_ANGLE_DURATION)
						s_d.ang_time = pwdata[15:0];
				`SSM_IDX_IRQ_CLEAR: s_d.ists = s_q.ists & ~pwdata[`SSM_IRQ_W-1:0];
				`SSM_IDX_IRQ_ENABLE: s_d.ien = pwdata[`SSM_IRQ_W-1:0];
				default: s_d.ien = s_q.ien;
			endcase
		end

		// tuned offsets overwrite the manual ones
		if (tune_valid)
		begin
			s_d.ofs_u = tune_u;
			s_d.ofs_v = tune_v;
			s_d.ofs_w = tune_w;
		end

		// warning and alarm masking
		warn_n = warning_raw & ~s_q.wmask[7:0];
		alarm_n = index_loss_alarm_raw && !s_q.wmask[14];
		s_d.warn = warn_n;
		s_d.alarm = alarm_n;

		// emergency stop sequence
		trig = positive_travel_limit_input || negative_travel_limit_input
			|| emergency_stop_input;
		case (s_q.stop)
			ssm_pkg::SSM_RUN:
				if (trig)
				begin
					if (s_q.stop_method[0] && !torque_mode)
						s_d.stop = ssm_pkg::SSM_DECEL;
					else
						s_d.stop = ssm_pkg::SSM_BRAKE;
				end
			ssm_pkg::SSM_BRAKE,
			ssm_pkg::SSM_DECEL:
				if (motor_standstill)
					s_d.stop = ssm_pkg::SSM_HALTED;
			ssm_pkg::SSM_HALTED:
				if (!trig)
					s_d.stop = ssm_pkg::SSM_RUN;
			default: s_d.stop = ssm_pkg::SSM_RUN;
		endcase

		s_d.stopping = (s_d.stop != ssm_pkg::SSM_RUN);
		s_d.decel = (s_d.stop == ssm_pkg::SSM_DECEL);
		s_d.tzero = (s_d.stop == ssm_pkg::SSM_BRAKE) || (s_d.stop == ssm_pkg::SSM_HALTED);
		case (s_d.stop)
			// coast modes let the motor run free while it stops
			ssm_pkg::SSM_BRAKE: s_d.dbrake = !s_q.db_mode[1];
			ssm_pkg::SSM_HALTED: s_d.dbrake = db_hold(s_q.db_mode);
			default: s_d.dbrake = 1'b0;
		endcase

		// initial-angle commutation at the first servo on
		s_d.servo_d = servo_on;
		if (s_q.ang_act)
		begin
			if (s_q.tick == TW'(TICKS_PER_MS - 1))
			begin
				s_d.tick = '0;
				s_d.ms = s_q.ms + 16'h0001;
				if (s_q.ms + 16'h0001 >= s_q.ang_time)
				begin
					s_d.ang_act = 1'b0;
					comm_done = 1'b1;
				end
			end
			else
				s_d.tick = s_q.tick + TW'(1);
		end
		else if (servo_on && !s_q.servo_d && !s_q.ang_used
			&& s_q.meth_a == 16'h0001)
		begin
			s_d.ang_act = 1'b1;
			s_d.ang_used = 1'b1;
			s_d.tick = '0;
			s_d.ms = 16'h0000;
		end

		// interrupt events; a new event wins over a clear in the same cycle
		ev = '0;
		ev[7:0] = warn_n & ~s_q.warn;
		ev[`SSM_IRQ_ALARM] = alarm_n && !s_q.alarm;
		ev[`SSM_IRQ_STOP] = (s_q.stop == ssm_pkg::SSM_RUN) && (s_d.stop != ssm_pkg::SSM_RUN);
		ev[`SSM_IRQ_COMM_DONE] = comm_done;
		s_d.ists = s_d.ists | ev;
		s_d.irq = |(s_d.ists & s_d.ien);
	end

	// ========================================================================
	// state register
	// ========================================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.db_mode <= `SSM_RST_DB_MODE;
			s_q.stop_method <= `SSM_RST_STOP_METHOD;
			s_q.wmask <= `SSM_RST_WARN_MASK;
			s_q.ofs_u <= `SSM_RST_OFS;
			s_q.ofs_v <= `SSM_RST_OFS;
			s_q.ofs_w <= `SSM_RST_OFS;
			s_q.pole_w <= `SSM_RST_POLE_PITCH;
			s_q.scale_w <= `SSM_RST_SCALE_SIZE;
			s_q.meth_w <= `SSM_RST_ANGLE_METHOD;
			s_q.ang_cur <= `SSM_RST_ANGLE_CURRENT;
			s_q.ang_time <= `SSM_RST_ANGLE_DURATION;
			s_q.pole_a <= `SSM_RST_POLE_PITCH;
			s_q.scale_a <= `SSM_RST_SCALE_SIZE;
			s_q.meth_a <= `SSM_RST_ANGLE_METHOD;
			s_q.stop <= ssm_pkg::SSM_RUN;
		end
		else
			s_q <= s_d;
	end

	// ========================================================================
	// current offset stage
	// ========================================================================
	assign cur.meas_u = meas_u;
	assign cur.meas_v = meas_v;
	assign cur.meas_w = meas_w;
	assign cur.ofs_u = s_q.ofs_u;
	assign cur.ofs_v = s_q.ofs_v;
	assign cur.ofs_w = s_q.ofs_w;
	assign cur.w_ignore = !large_drive;

	ssm_offset u_offset (
		.pclk(pclk),
		.presetn(presetn),
		.cur(cur)
	);

	// ========================================================================
	// outputs
	// ========================================================================
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign irq = s_q.irq;
	assign ctrl_u = cur.ctrl_u;
	assign ctrl_v = cur.ctrl_v;
	assign ctrl_w = cur.ctrl_w;
	assign stop_active = s_q.stopping;
	assign dynamic_brake = s_q.dbrake;
	assign torque_zero = s_q.tzero;
	assign decel_stop = s_q.decel;
	assign warning_out = s_q.warn;
	assign index_loss_alarm = s_q.alarm;
	assign pole_pitch = s_q.pole_a;
	assign scale_size = s_q.scale_a;
	assign angle_on_first_servo = s_q.ang_first;
	assign angle_active = s_q.ang_act;
	assign angle_current = s_q.ang_cur;

endmodule

`default_nettype wire

// [common/ssm_regs.svh]
// register indices, reset values, ranges and timing constants of the stop, mask and
// commutation parameter bank; assumes word registers at byte address four times the index
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

// register indices (byte address = index * 4)
`define SSM_IDX_DB_MODE 14'h2012
`define SSM_IDX_STOP_METHOD 14'h2013
`define SSM_IDX_WARN_MASK 14'h2014
`define SSM_IDX_OFS_U 14'h2015
`define SSM_IDX_OFS_V 14'h2016
`define SSM_IDX_OFS_W 14'h2017
`define SSM_IDX_POLE_PITCH 14'h2018
`define SSM_IDX_SCALE_SIZE 14'h2019
`define SSM_IDX_ANGLE_METHOD 14'h201A
`define SSM_IDX_ANGLE_CURRENT 14'h201B
`define SSM_IDX_ANGLE_DURATION 14'h201C
`define SSM_IDX_IRQ_STATUS 14'h2030
`define SSM_IDX_IRQ_CLEAR 14'h2031
`define SSM_IDX_IRQ_ENABLE 14'h2032

// power-up values
`define SSM_RST_DB_MODE 16'h0000
`define SSM_RST_STOP_METHOD 16'h0001
`define SSM_RST_WARN_MASK 16'h0000
`define SSM_RST_OFS 16'h0000
`define SSM_RST_POLE_PITCH 16'h0960
`define SSM_RST_SCALE_SIZE 16'h03E8
`define SSM_RST_ANGLE_METHOD 16'h0000
`define SSM_RST_ANGLE_CURRENT 16'h01F4
`define SSM_RST_ANGLE_DURATION 16'h03E8

// accepted ranges
`define SSM_MAX_DB_MODE 16'h0003
`define SSM_MAX_STOP_METHOD 16'h0001
`define SSM_OFS_LIMIT 16'sh03E8
`define SSM_MAX_ANGLE_METHOD 16'h0002
`define SSM_MAX_ANGLE_CURRENT 16'h03E8
`define SSM_MIN_ANGLE_DURATION 16'h01F4
`define SSM_MAX_ANGLE_DURATION 16'h1388

// timing
`define SSM_CLK_HZ 10000000
`define SSM_MS_PER_S 1000

// interrupt status layout
`define SSM_IRQ_W 11
`define SSM_IRQ_ALARM 8
`define SSM_IRQ_STOP 9
`define SSM_IRQ_COMM_DONE 10

`endif

// [common/ssm_pkg.sv]
// types shared by the parameter bank and its current offset stage
// assumes the constants header is included by the modules that need numbers
package ssm_pkg;

	typedef enum logic [1:0] {
		SSM_RUN = 2'b00,
		SSM_BRAKE = 2'b01,
		SSM_DECEL = 2'b10,
		SSM_HALTED = 2'b11
	} ssm_stop_t;

	typedef enum logic [1:0] {
		SSM_DB_HOLD_BRAKED = 2'b00,
		SSM_DB_FREE_BRAKED = 2'b01,
		SSM_DB_FREE_COAST = 2'b10,
		SSM_DB_HOLD_COAST = 2'b11
	} ssm_db_mode_t;

	typedef logic signed [15:0] ssm_cur_t;

endpackage

// [common/ssm_cur_if.sv]
// bundle between the parameter bank and its per-phase offset stage
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface ssm_cur_if;
	ssm_pkg::ssm_cur_t meas_u;
	ssm_pkg::ssm_cur_t meas_v;
	ssm_pkg::ssm_cur_t meas_w;
	ssm_pkg::ssm_cur_t ofs_u;
	ssm_pkg::ssm_cur_t ofs_v;
	ssm_pkg::ssm_cur_t ofs_w;
	logic w_ignore;
	ssm_pkg::ssm_cur_t ctrl_u;
	ssm_pkg::ssm_cur_t ctrl_v;
	ssm_pkg::ssm_cur_t ctrl_w;

	modport bank (output meas_u, meas_v, meas_w, ofs_u, ofs_v, ofs_w, w_ignore,
		input ctrl_u, ctrl_v, ctrl_w);
	modport calc (input meas_u, meas_v, meas_w, ofs_u, ofs_v, ofs_w, w_ignore,
		output ctrl_u, ctrl_v, ctrl_w);
endinterface

`default_nettype wire

// [rtl/ssm_offset.sv]
// per-phase current offset stage: registered, saturating subtraction
// assumes offsets already lie inside the accepted range
`timescale 1ns/100ps
`default_nettype none

module ssm_offset (
	input wire logic pclk,
	input wire logic presetn,
	ssm_cur_if.calc cur
);

	typedef struct packed {
		ssm_pkg::ssm_cur_t u;
		ssm_pkg::ssm_cur_t v;
		ssm_pkg::ssm_cur_t w;
	} ssm_ofs_state_t;

	ssm_ofs_state_t s_q;
	ssm_ofs_state_t s_d;

	// difference clipped to the 16-bit signed range
	function automatic ssm_pkg::ssm_cur_t sub_sat(input ssm_pkg::ssm_cur_t a,
		input ssm_pkg::ssm_cur_t b);
		logic signed [16:0] diff;
		diff = 17'(a) - 17'(b);
		if (diff > 17'sh07FFF)
			sub_sat = 16'sh7FFF;
		else if (diff < -17'sh08000)
			sub_sat = 16'sh8000;
		else
			sub_sat = diff[15:0];
	endfunction

	always_comb
	begin
		s_d = s_q;
		s_d.u = sub_sat(cur.meas_u, cur.ofs_u);
		s_d.v = sub_sat(cur.meas_v, cur.ofs_v);
		// small drives do not measure the w phase on its own
		s_d.w = cur.w_ignore ? cur.meas_w : sub_sat(cur.meas_w, cur.ofs_w);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign cur.ctrl_u = s_q.u;
	assign cur.ctrl_v = s_q.v;
	assign cur.ctrl_w = s_q.w;

endmodule

`default_nettype wire

// [dv/ssm_top_sva.sv]
// assertion checker of the stop, mask and offset parameter bank
// assumes it is bound to ssm_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none

module ssm_top_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic positive_travel_limit_input,
	input wire logic negative_travel_limit_input,
	input wire logic emergency_stop_input,
	input wire logic torque_mode,
	input wire logic large_drive,
	input wire logic servo_on,
	input wire logic [7:0] warning_raw,
	input wire logic [7:0] warning_out,
	input wire logic index_loss_alarm_raw,
	input wire logic index_loss_alarm,
	input wire logic [15:0] meas_w,
	input wire logic [15:0] ctrl_w,
	input wire logic stop_active,
	input wire logic dynamic_brake,
	input wire logic torque_zero,
	input wire logic decel_stop,
	input wire logic angle_active
);
	wire logic trig;
	assign trig = positive_travel_limit_input | negative_travel_limit_input | emergency_stop_input;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ================================
	// checks
	a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");
	a_warn_masked: assert property ((warning_out & ~$past(warning_raw)) == 8'h00)
		else $error("warning raised without cause");
	a_alarm_cause: assert property (index_loss_alarm |-> $past(index_loss_alarm_raw))
		else $error("alarm raised without cause");
	a_stop_entry: assert property (trig && !stop_active |=> stop_active)
		else $error("stop not entered");
	a_decel_free: assert property (decel_stop |-> !dynamic_brake && !torque_zero)
		else $error("decel stop with brake or zero torque");
	a_torque_no_decel: assert property (torque_mode && trig && !stop_active |=> !decel_stop)
		else $error("decel stop in torque mode");
	a_brake_zero: assert property (dynamic_brake && stop_active |-> torque_zero)
		else $error("brake without zero torque");
	a_w_bypass: assert property ($past(presetn) && !$past(large_drive) |-> ctrl_w == $past(meas_w))
		else $error("w offset used on small drive");
	a_angle_start: assert property ($rose(angle_active) |-> $past(servo_on))
		else $error("commutation without servo on");
endmodule

`default_nettype wire

// [dv/testbench.sv]
// self-checking bench of the stop, mask, offset and commutation parameter bank
// assumes ssm_top with apb on pclk; the checker is bound at the foot
`timescale 1ns/100ps
`default_nettype none

module testbench;
	localparam int TPM = 10;
	localparam logic [15:0] RV [11] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0960, 16'h03E8, 16'h0000, 16'h01F4, 16'h03E8};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic torque_mode, motor_standstill, servo_on, large_drive, tune_valid;
	logic [2:0] trg;
	logic [7:0] warning_raw, warning_out;
	logic index_loss_alarm_raw, index_loss_alarm;
	logic [15:0] tune_u, tune_v, tune_w, meas_u, meas_v, meas_w, ctrl_u, ctrl_v, ctrl_w;
	logic stop_active, dynamic_brake, torque_zero, decel_stop, angle_on_first_servo, angle_active;
	logic [15:0] pole_pitch, scale_size, angle_current, ou, ov, mu, mv, mw;
	logic [33:0] q[$];
	logic [33:0] e;
	int n_fail, total_checks, cnt;

	ssm_top #(.TICKS_PER_MS(TPM)) ssm_top_inst (.*, .positive_travel_limit_input(trg[0]),
		.negative_travel_limit_input(trg[1]), .emergency_stop_input(trg[2]));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ================================
	// tasks
	task report_and_stop;
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic apb(input logic w, input logic [13:0] i, input logic [15:0] d,
		input logic [33:0] x);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {16'h0000, d};
		q.push_back(x);
		@(posedge pclk);
		penable <= 1'b1;
		#1;
		// the transfer completes at the first edge that sees pready high
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
			#1;
		end
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [13:0] i, input logic [15:0] d);
		apb(1'b1, i, d, 34'h0);
	endtask

	task automatic rd(input logic [13:0] i, input logic [15:0] x, input logic er = 1'b0);
		apb(1'b0, i, 16'h0000, {1'b1, er, 16'h0000, x});
	endtask

	task automatic stop_seq(input int t, input logic db, tz, dc, hold);
		@(posedge pclk);
		trg[t] <= 1'b1;
		tick(2);
		chk(stop_active, 1'b1);
		chk(dynamic_brake, db);
		chk(torque_zero, tz);
		chk(decel_stop, dc);
		@(posedge pclk);
		motor_standstill <= 1'b1;
		tick(2);
		if (!dc)
			chk(dynamic_brake, hold);
		@(posedge pclk);
		trg <= 3'b000;
		motor_standstill <= 1'b0;
		tick(2);
		chk(stop_active | dynamic_brake | torque_zero, 1'b0);
	endtask

	// ================================
	// results of bus transfers
	// sampled mid-cycle, while the access phase answer stands
	always @(negedge pclk)
		if (psel && penable && pready)
		begin
			e = q.pop_front();
			chk(pslverr, e[32]);
			if (e[33])
				chk(prdata, e[31:0]);
		end

	initial
	begin
		#(20000 * 100);
		n_fail++;
		report_and_stop;
	end

	// ================================
	// scenarios
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, trg, torque_mode} = '0;
		{motor_standstill, servo_on, large_drive, tune_valid, warning_raw} = '0;
		{index_loss_alarm_raw, tune_u, tune_v, tune_w, meas_u, meas_v, meas_w} = '0;
		n_fail = 0;
		total_checks = 0;
		void'($urandom(32'h238638E0));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int j = 0; j < 11; j++)
			rd(14'(14'h2012 + j), RV[j]);
		rd(14'h2040, 16'h0000, 1'b1);
		chk(pole_pitch, 16'h0960);
		chk(scale_size, 16'h03E8);
		mu = 16'($urandom);
		mv = 16'($urandom);
		wr(14'h2014, mu | 16'h4000);
		@(posedge pclk);
		warning_raw <= mv[7:0];
		index_loss_alarm_raw <= 1'b1;
		tick(2);
		chk(warning_out, 8'(mv[7:0] & ~mu[7:0]));
		chk(index_loss_alarm, 1'b0);
		wr(14'h2014, 16'h0000);
		tick(2);
		chk(warning_out, mv[7:0]);
		chk(index_loss_alarm, 1'b1);
		@(posedge pclk);
		warning_raw <= 8'h00;
		index_loss_alarm_raw <= 1'b0;
		ou = 16'($urandom_range(2000) - 1000);
		ov = 16'($urandom_range(2000) - 1000);
		wr(14'h2015, ou);
		wr(14'h2016, ov);
		wr(14'h2017, 16'hFC18);
		wr(14'h2015, 16'h03E9);
		rd(14'h2015, ou);
		mu = 16'($urandom_range(20000) - 10000);
		mv = 16'($urandom_range(20000) - 10000);
		mw = 16'($urandom_range(20000) - 10000);
		@(posedge pclk);
		meas_u <= mu;
		meas_v <= mv;
		meas_w <= mw;
		tick(2);
		chk(ctrl_u, 16'(mu - ou));
		chk(ctrl_v, 16'(mv - ov));
		chk(ctrl_w, mw);
		@(posedge pclk);
		large_drive <= 1'b1;
		tick(2);
		chk(ctrl_w, 16'(mw + 16'd1000));
		@(posedge pclk);
		tune_valid <= 1'b1;
		{tune_u, tune_v, tune_w} <= {ov, ou, 16'h0064};
		@(posedge pclk);
		tune_valid <= 1'b0;
		rd(14'h2015, ov);
		rd(14'h2016, ou);
		rd(14'h2017, 16'h0064);
		wr(14'h2031, 16'h07FF);
		wr(14'h2013, 16'h0000);
		wr(14'h2013, 16'h0002);
		rd(14'h2013, 16'h0000);
		for (int m = 0; m < 4; m++)
		begin
			wr(14'h2012, 16'(m));
			stop_seq(m % 3, m < 2, 1'b1, 1'b0, m == 0 || m == 3);
		end
		chk(irq, 1'b0);
		wr(14'h2032, 16'h0200);
		tick(2);
		chk(irq, 1'b1);
		rd(14'h2030, 16'h0200);
		wr(14'h2031, 16'h0200);
		tick(2);
		chk(irq, 1'b0);
		rd(14'h2030, 16'h0000);
		wr(14'h2012, 16'h0000);
		wr(14'h2013, 16'h0001);
		stop_seq(2, 1'b0, 1'b0, 1'b1, 1'b0);
		@(posedge pclk);
		torque_mode <= 1'b1;
		stop_seq(1, 1'b1, 1'b1, 1'b0, 1'b1);
		@(posedge pclk);
		torque_mode <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		tick(2);
		chk(pole_pitch, 16'h0960);
		chk(angle_current, 16'h01F4);
		wr(14'h2018, 16'h1234);
		wr(14'h2019, 16'h07D0);
		wr(14'h201A, 16'h0001);
		rd(14'h2018, 16'h1234);
		chk(pole_pitch, 16'h1234);
		chk(scale_size, 16'h07D0);
		wr(14'h201C, 16'h01F4);
		wr(14'h201B, 16'h0100);
		wr(14'h2032, 16'h0400);
		tick(2);
		chk(angle_current, 16'h0100);
		@(posedge pclk);
		servo_on <= 1'b1;
		tick(2);
		cnt = 1;
		while (angle_active === 1'b1 && cnt < 6000)
		begin
			tick(1);
			cnt++;
		end
		chk(cnt, 500 * TPM);
		chk(angle_on_first_servo, 1'b1);
		tick(2);
		chk(irq, 1'b1);
		rd(14'h2030, 16'h0400);
		wr(14'h2018, 16'h0BB8);
		rd(14'h2018, 16'h0BB8);
		chk(pole_pitch, 16'h1234);
		report_and_stop;
	end
endmodule

bind ssm_top ssm_top_sva ssm_top_sva_inst (.*);

`default_nettype wire
